// ### verilog/nvac_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the nonvolatile access block
// ----------------------------------------------------------------
package nvac_pkg;

    // Register page that holds the array and its control registers
    localparam logic [3:0] NV_PAGE = 4'h5;

    // Array geometry: 64 rows of two bytes
    localparam int ARRAY_BYTES = 128;
    localparam int ROW_W = 6;
    localparam int IDX_W = 7;
    localparam logic [7:0] ERASED_VAL = 8'h00;

    // Register offsets inside the page
    localparam logic [7:0] OFF_WIN_LAST = 8'h7F;
    localparam logic [7:0] OFF_BUF_LO = 8'h80;
    localparam logic [7:0] OFF_BUF_HI = 8'h81;
    localparam logic [7:0] OFF_ROW = 8'h82;
    localparam logic [7:0] OFF_CMD = 8'h83;
    localparam logic [7:0] OFF_CSUM_CMD = 8'h84;
    localparam logic [7:0] OFF_STATUS = 8'h85;
    localparam logic [7:0] OFF_CSUM_STAT = 8'h86;
    localparam logic [7:0] OFF_CSUM_VAL = 8'h87;

    // Field positions
    localparam int CMD_PROG_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_W = 3;
    localparam int CSUM_START_BIT = 0;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CSUM_RST = 8'h01;

    // Checksum polynomial and seed
    localparam logic [7:0] CSUM_POLY = 8'h07;
    localparam logic [7:0] CSUM_SEED = 8'hFF;

    // Array timing, times in ns, counts at 125 MHz rounded up
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_NS = 2000;
    localparam int ERASE_TIME_NS = 2000;
    localparam logic [15:0] PROG_CYC =
        16'((PROG_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] ERASE_CYC =
        16'((ERASE_TIME_NS * CLK_MHZ + 999) / 1000);

    // Array operation in flight
    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} nvac_op_t;

endpackage

// ### verilog/nvac_csum.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Checksum engine: walks the array one byte per clock
// ----------------------------------------------------------------
module nvac_csum #(
    parameter int N = nvac_pkg::ARRAY_BYTES
) (
    input wire logic clk, // Device clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic start, // Begin a walk
    input wire logic [7:0] byte_in, // Array byte at idx_r
    input wire logic [7:0] last_byte, // Stored checksum byte
    output logic [nvac_pkg::IDX_W-1:0] idx_r, // Byte being read
    output logic busy_r, // Walk ongoing
    output logic done_r, // Walk finished, one cycle
    output logic good_r, // Stored matches calculated
    output logic [7:0] crc_r // Calculated checksum
);
    localparam logic [nvac_pkg::IDX_W-1:0] LAST_IDX =
        nvac_pkg::IDX_W'(N - 2);

    logic [7:0] acc_r;
    logic [7:0] acc_nxt;

    // One byte step of the checksum, msb first
    function automatic logic [7:0] csum_step(input logic [7:0] c,
                                             input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ((x << 1) ^ nvac_pkg::CSUM_POLY) : (x << 1);
        end
        return x;
    endfunction

    assign acc_nxt = csum_step(acc_r, byte_in);

    // Walk over every byte but the last, then compare
    always_ff @(posedge clk) begin
        if (!nrst) begin
            idx_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            good_r <= 1'b0;
            acc_r <= nvac_pkg::CSUM_SEED;
            crc_r <= nvac_pkg::CSUM_RST;
        end else if (start && !busy_r) begin
            idx_r <= '0;
            busy_r <= 1'b1;
            done_r <= 1'b0;
            acc_r <= nvac_pkg::CSUM_SEED;
        end else if (busy_r) begin
            acc_r <= acc_nxt;
            idx_r <= idx_r + 1'b1;
            if (idx_r == LAST_IDX) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
                crc_r <= acc_nxt;
                good_r <= acc_nxt == last_byte;
            end
        end else begin
            done_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_walk;
        busy_r ##126 busy_r ##1 (!busy_r && done_r);
    endsequence

    a_csum_walk_len: assert property (
        @(posedge clk) disable iff (!nrst)
        start && !busy_r |=> s_walk)
        else $error("checksum walk length wrong");

    a_csum_good_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        done_r |-> good_r == (crc_r == last_byte))
        else $error("checksum match flag wrong");

endmodule

// ### verilog/nvac_top.sv
`timescale 1ns/1ps
// How it works
// - Page 5 offsets 0x00-0x7F read back the stored array bytes directly.
// - Offset 0x80 holds first write-buffer byte, read/write, resets zero.
// - Offset 0x81 holds second write-buffer byte, read/write, resets zero.
// - Offset 0x82 bits 5:0 select the row; bits 7:6 reserved.
// - Writing 1 to 0x83 bit 0 programs the buffer into selected row.
// - Writing 1 to 0x83 bit 1 with bit 0 clear erases the selected row.
// - Writing 1 to 0x84 bit 0 starts the array checksum.
// - Offset 0x85 bits 0,1,2 show read, erase, program busy.
// - Offset 0x86 bit 0 checksum busy, bit 1 checksum match.
// - Offset 0x87 reads the calculated 8-bit checksum.
module nvac_top #(
    parameter logic [15:0] PROG_CYC = nvac_pkg::PROG_CYC,
    parameter logic [15:0] ERASE_CYC = nvac_pkg::ERASE_CYC
) (
    input wire logic clk, // Device clock, 125 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [3:0] rif_page, // Register page of access
    input wire logic [7:0] rif_offset, // Offset within page
    input wire logic rif_wr, // Write strobe, one cycle
    input wire logic rif_rd, // Read strobe, one cycle
    input wire logic [7:0] rif_wdata, // Write data
    output logic [7:0] rif_rdata_r, // Read data
    output logic rif_rvalid_r // Read data valid, one cycle
);
    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [7:0] mem_r [nvac_pkg::ARRAY_BYTES];
    logic [7:0] buf_lo_r;
    logic [7:0] buf_hi_r;
    logic [nvac_pkg::ROW_W-1:0] row_r;
    logic [nvac_pkg::CMD_W-1:0] cmd_r;
    logic csum_cmd_r;
    logic rd_busy_r;
    nvac_pkg::nvac_op_t op_r;
    logic [15:0] op_cnt_r;
    logic [nvac_pkg::ROW_W-1:0] lat_row_r;
    logic [7:0] lat_lo_r;
    logic [7:0] lat_hi_r;

    // Checksum engine outputs
    logic [nvac_pkg::IDX_W-1:0] cs_idx;
    logic cs_busy;
    logic cs_done;
    logic cs_good;
    logic [7:0] cs_val;

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    wire page_hit = rif_page == nvac_pkg::NV_PAGE;
    wire wr_hit = rif_wr && page_hit;
    wire rd_hit = rif_rd && page_hit;
    wire in_win = rif_offset <= nvac_pkg::OFF_WIN_LAST;
    wire sel_lo = wr_hit && rif_offset == nvac_pkg::OFF_BUF_LO;
    wire sel_hi = wr_hit && rif_offset == nvac_pkg::OFF_BUF_HI;
    wire sel_row = wr_hit && rif_offset == nvac_pkg::OFF_ROW;
    wire sel_cmd = wr_hit && rif_offset == nvac_pkg::OFF_CMD;
    wire sel_csum = wr_hit && rif_offset == nvac_pkg::OFF_CSUM_CMD;

    // Commands are taken only while nothing is running
    wire idle = op_r == nvac_pkg::OP_IDLE && !cs_busy;
    wire wr_prog = rif_wdata[nvac_pkg::CMD_PROG_BIT];
    wire wr_erase = rif_wdata[nvac_pkg::CMD_ERASE_BIT];
    wire start_prog = sel_cmd && idle && wr_prog;
    wire start_erase = sel_cmd && idle && !wr_prog && wr_erase;
    wire start_csum = sel_csum && idle &&
        rif_wdata[nvac_pkg::CSUM_START_BIT];
    wire op_last = op_r != nvac_pkg::OP_IDLE && op_cnt_r == 16'h0000;
    wire prog_busy = op_r == nvac_pkg::OP_PROG;
    wire erase_busy = op_r == nvac_pkg::OP_ERASE;

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Write buffer and row select, writable at any time
    always_ff @(posedge clk) begin
        if (!nrst) begin
            buf_lo_r <= nvac_pkg::RST_BYTE;
            buf_hi_r <= nvac_pkg::RST_BYTE;
            row_r <= '0;
        end else begin
            if (sel_lo) buf_lo_r <= rif_wdata;
            if (sel_hi) buf_hi_r <= rif_wdata;
            if (sel_row) row_r <= rif_wdata[nvac_pkg::ROW_W-1:0];
        end
    end

    // Command bits stand until their operation ends
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_r <= '0;
            csum_cmd_r <= 1'b0;
        end else begin
            if (sel_cmd && idle) begin
                cmd_r <= rif_wdata[nvac_pkg::CMD_W-1:0];
            end else if (op_last) begin
                cmd_r[1:0] <= 2'h0;
            end
            if (sel_csum && idle) begin
                csum_cmd_r <= rif_wdata[nvac_pkg::CSUM_START_BIT];
            end else if (cs_done) begin
                csum_cmd_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Program and erase sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            op_r <= nvac_pkg::OP_IDLE;
            op_cnt_r <= 16'h0000;
        end else begin
            unique case (op_r)
                nvac_pkg::OP_IDLE: begin
                    if (start_prog) begin
                        op_r <= nvac_pkg::OP_PROG;
                        op_cnt_r <= PROG_CYC - 16'h0001;
                    end else if (start_erase) begin
                        op_r <= nvac_pkg::OP_ERASE;
                        op_cnt_r <= ERASE_CYC - 16'h0001;
                    end
                end
                nvac_pkg::OP_PROG, nvac_pkg::OP_ERASE: begin
                    if (op_cnt_r == 16'h0000) begin
                        op_r <= nvac_pkg::OP_IDLE;
                    end else begin
                        op_cnt_r <= op_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Row and data captured at start so later writes cannot disturb
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lat_row_r <= '0;
            lat_lo_r <= nvac_pkg::RST_BYTE;
            lat_hi_r <= nvac_pkg::RST_BYTE;
        end else if (start_prog || start_erase) begin
            lat_row_r <= row_r;
            lat_lo_r <= buf_lo_r;
            lat_hi_r <= buf_hi_r;
        end
    end

    // ----------------------------------------------------------------
    // Array cells
    // ----------------------------------------------------------------
    for (genvar g = 0; g < nvac_pkg::ARRAY_BYTES; g++) begin : g_cell
        localparam bit ODD = (g % 2) == 1;
        localparam logic [nvac_pkg::ROW_W-1:0] ROW =
            nvac_pkg::ROW_W'(g / 2);
        wire hit = op_last && lat_row_r == ROW;
        wire [7:0] pdat = ODD ? lat_hi_r : lat_lo_r;
        wire [7:0] wd = prog_busy ? pdat : nvac_pkg::ERASED_VAL;

        // A cell changes only when its row's operation completes
        always_ff @(posedge clk) begin
            if (!nrst) begin
                mem_r[g] <= nvac_pkg::RST_BYTE;
            end else if (hit) begin
                mem_r[g] <= wd;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checksum engine
    // ----------------------------------------------------------------
    nvac_csum #(
        .N(nvac_pkg::ARRAY_BYTES)
    ) u_csum (
        .clk(clk),
        .nrst(nrst),
        .start(start_csum),
        .byte_in(mem_r[cs_idx]),
        .last_byte(mem_r[nvac_pkg::ARRAY_BYTES-1]),
        .idx_r(cs_idx),
        .busy_r(cs_busy),
        .done_r(cs_done),
        .good_r(cs_good),
        .crc_r(cs_val)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [7:0] stat_val = {5'h00, prog_busy, erase_busy, rd_busy_r};
    wire [7:0] cstat_val = {6'h00, cs_good, cs_busy};
    wire [7:0] reg_mux =
        rif_offset == nvac_pkg::OFF_BUF_LO ? buf_lo_r :
        rif_offset == nvac_pkg::OFF_BUF_HI ? buf_hi_r :
        rif_offset == nvac_pkg::OFF_ROW ? {2'h0, row_r} :
        rif_offset == nvac_pkg::OFF_CMD ? {5'h00, cmd_r} :
        rif_offset == nvac_pkg::OFF_CSUM_CMD ? {7'h00, csum_cmd_r} :
        rif_offset == nvac_pkg::OFF_STATUS ? stat_val :
        rif_offset == nvac_pkg::OFF_CSUM_STAT ? cstat_val :
        rif_offset == nvac_pkg::OFF_CSUM_VAL ? cs_val :
        8'h00;
    wire [7:0] win_val = mem_r[rif_offset[nvac_pkg::IDX_W-1:0]];
    wire [7:0] rd_mux = !page_hit ? 8'h00 :
        in_win ? win_val : reg_mux;

    // Read answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rif_rdata_r <= 8'h00;
            rif_rvalid_r <= 1'b0;
            rd_busy_r <= 1'b0;
        end else begin
            rif_rvalid_r <= rif_rd;
            if (rif_rd) rif_rdata_r <= rd_mux;
            rd_busy_r <= rd_hit && in_win;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_prog_run;
        ##249 prog_busy ##1 !prog_busy;
    endsequence

    sequence s_erase_run;
        ##249 erase_busy ##1 !erase_busy;
    endsequence

    a_prog_run_time: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(prog_busy) |-> s_prog_run)
        else $error("program busy time wrong");

    a_erase_run_time: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(erase_busy) |-> s_erase_run)
        else $error("erase busy time wrong");

    a_prog_row_data: assert property (
        @(posedge clk) disable iff (!nrst)
        $fell(prog_busy) |->
        mem_r[{lat_row_r, 1'b0}] == lat_lo_r &&
        mem_r[{lat_row_r, 1'b1}] == lat_hi_r)
        else $error("program did not store buffer");

    a_erase_row_clr: assert property (
        @(posedge clk) disable iff (!nrst)
        $fell(erase_busy) |->
        mem_r[{lat_row_r, 1'b0}] == nvac_pkg::ERASED_VAL &&
        mem_r[{lat_row_r, 1'b1}] == nvac_pkg::ERASED_VAL)
        else $error("erase did not clear row");

    a_cmd_zero_noop: assert property (
        @(posedge clk) disable iff (!nrst)
        sel_cmd && idle && rif_wdata[1:0] == 2'h0 |=>
        op_r == nvac_pkg::OP_IDLE)
        else $error("zero command started an operation");

    a_cmd_busy_drop: assert property (
        @(posedge clk) disable iff (!nrst)
        sel_cmd && !idle && !op_last |=> cmd_r == $past(cmd_r))
        else $error("command taken while busy");

    a_buf_lo_write: assert property (
        @(posedge clk) disable iff (!nrst)
        sel_lo |=> buf_lo_r == $past(rif_wdata))
        else $error("low buffer byte not stored");

    a_buf_hi_write: assert property (
        @(posedge clk) disable iff (!nrst)
        sel_hi |=> buf_hi_r == $past(rif_wdata))
        else $error("high buffer byte not stored");

    a_win_read_data: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_hit && in_win && op_r == nvac_pkg::OP_IDLE |=>
        rif_rvalid_r && rd_busy_r &&
        rif_rdata_r == mem_r[$past(rif_offset[6:0])])
        else $error("window read returned wrong byte");

    a_row_rsv_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_hit && rif_offset == nvac_pkg::OFF_ROW |=>
        rif_rdata_r[7:6] == 2'h0)
        else $error("row select reserved bits not zero");

    a_csum_start: assert property (
        @(posedge clk) disable iff (!nrst)
        start_csum |=> cs_busy ##1 cs_busy)
        else $error("checksum did not start");

    a_csum_readback: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_hit && rif_offset == nvac_pkg::OFF_CSUM_VAL |=>
        rif_rdata_r == $past(cs_val))
        else $error("checksum value read wrong");

    a_busy_reads: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_hit && rif_offset == nvac_pkg::OFF_STATUS && prog_busy |=>
        rif_rdata_r[2])
        else $error("program busy not reported");

    a_erase_busy_bit: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_hit && rif_offset == nvac_pkg::OFF_STATUS && erase_busy |=>
        rif_rdata_r[1])
        else $error("erase busy not reported");

    a_csum_busy_bit: assert property (
        @(posedge clk) disable iff (!nrst)
        rd_hit && rif_offset == nvac_pkg::OFF_CSUM_STAT |=>
        rif_rdata_r[0] == $past(cs_busy))
        else $error("checksum busy not reported");

endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register-level bench for the nonvolatile access block
// ----------------------------------------------------------------
`define CHK(nm, exp, got) \
    begin \
        comparisons = comparisons + 1; \
        if ((got) !== (exp)) begin \
            err_total = err_total + 1; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end

module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] rif_page = 4'h5;
    logic [7:0] rif_offset = 8'h00;
    logic rif_wr = 1'b0;
    logic rif_rd = 1'b0;
    logic [7:0] rif_wdata = 8'h00;
    logic [7:0] rif_rdata_r;
    logic rif_rvalid_r;
    int err_total = 0;
    int comparisons = 0;
    logic [7:0] arr [0:127]; // Expected array contents
    logic [7:0] v;
    logic [7:0] c;

    nvac_top dut_u (
        .clk(clk),
        .nrst(nrst),
        .rif_page(rif_page),
        .rif_offset(rif_offset),
        .rif_wr(rif_wr),
        .rif_rd(rif_rd),
        .rif_wdata(rif_wdata),
        .rif_rdata_r(rif_rdata_r),
        .rif_rvalid_r(rif_rvalid_r)
    );

    // Clock, 8 ns period
    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // One write strobe, data and address held for the sampling edge
    task automatic wr(input logic [3:0] pg, input logic [7:0] off,
                      input logic [7:0] d);
        @(posedge clk);
        rif_page <= pg;
        rif_offset <= off;
        rif_wdata <= d;
        rif_wr <= 1'b1;
        @(posedge clk);
        rif_wr <= 1'b0;
    endtask

    // One read strobe, data taken one cycle later with its valid
    task automatic rd(input logic [3:0] pg, input logic [7:0] off,
                      output logic [7:0] d);
        @(posedge clk);
        rif_page <= pg;
        rif_offset <= off;
        rif_rd <= 1'b1;
        @(posedge clk);
        rif_rd <= 1'b0;
        #1;
        `CHK("read valid", 1'b1, rif_rvalid_r)
        d = rif_rdata_r;
    endtask

    // Read a page 5 offset and compare
    task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp,
                          input string nm);
        logic [7:0] d;
        rd(4'h5, off, d);
        `CHK(nm, exp, d)
    endtask

    // Poll status until program, erase and checksum are all idle
    task automatic wait_idle;
        logic [7:0] s0;
        logic [7:0] s1;
        int i;
        for (i = 0; i < 300; i++) begin
            rd(4'h5, 8'h85, s0);
            rd(4'h5, 8'h86, s1);
            if (s0 === 8'h00 && s1[0] === 1'b0) begin
                break;
            end
        end
        `CHK("idle wait", 1'b1, i < 300)
    endtask

    // Program one row through the buffer and update the expectation
    task automatic prog_row(input logic [5:0] row, input logic [7:0] lo,
                            input logic [7:0] hi);
        wr(4'h5, 8'h80, lo);
        wr(4'h5, 8'h81, hi);
        wr(4'h5, 8'h82, {2'b00, row});
        wr(4'h5, 8'h83, 8'h01);
        arr[{row, 1'b0}] = lo;
        arr[{row, 1'b1}] = hi;
    endtask

    // Reference checksum over bytes 0..126, msb first
    function automatic logic [7:0] crc_ref();
        logic [7:0] r;
        r = 8'hFF;
        for (int i = 0; i < 127; i++) begin
            r = r ^ arr[i];
            for (int b = 0; b < 8; b++) begin
                r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
            end
        end
        return r;
    endfunction

    // Run a checksum and compare busy, value and match flag
    task automatic run_csum;
        c = crc_ref();
        wr(4'h5, 8'h84, 8'h01);
        rd_chk(8'h86, 8'h01, "csum busy");
        wait_idle();
        rd_chk(8'h87, c, "csum value");
        rd_chk(8'h86, {6'h00, c === arr[127], 1'b0}, "csum match");
        rd_chk(8'h84, 8'h00, "csum start");
    endtask

    // Closing verdict
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #400000;
        err_total = err_total + 1;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) begin
            arr[i] = 8'h00;
        end
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset values of the register set
        rd_chk(8'h80, 8'h00, "buf lo reset");
        rd_chk(8'h81, 8'h00, "buf hi reset");
        rd_chk(8'h82, 8'h00, "row reset");
        rd_chk(8'h83, 8'h00, "cmd reset");
        rd_chk(8'h84, 8'h00, "csum cmd reset");
        rd_chk(8'h85, 8'h00, "status reset");
        rd_chk(8'h86, 8'h00, "csum stat reset");
        rd_chk(8'h87, 8'h01, "csum val reset");
        rd_chk(8'h7F, 8'h00, "window reset");
        // Buffer and row registers, reserved row bits read zero
        wr(4'h5, 8'h80, 8'hA5);
        wr(4'h5, 8'h81, 8'h5A);
        wr(4'h5, 8'h82, 8'hFF);
        rd_chk(8'h80, 8'hA5, "buf lo rw");
        rd_chk(8'h81, 8'h5A, "buf hi rw");
        rd_chk(8'h82, 8'h3F, "row rw");
        // Other pages and unmapped offsets are refused
        wr(4'h4, 8'h80, 8'h77);
        rd_chk(8'h80, 8'hA5, "other page write");
        rd(4'h4, 8'h80, v);
        `CHK("other page read", 8'h00, v)
        rd_chk(8'h90, 8'h00, "unmapped read");
        // Program a row, command while busy is dropped
        prog_row(6'h05, 8'h12, 8'h34);
        rd_chk(8'h85, 8'h04, "prog busy");
        wr(4'h5, 8'h83, 8'h02);
        rd_chk(8'h83, 8'h01, "cmd while busy");
        wait_idle();
        rd_chk(8'h83, 8'h00, "cmd cleared");
        rd_chk(8'h0A, 8'h12, "row lo prog");
        rd_chk(8'h0B, 8'h34, "row hi prog");
        rd_chk(8'h09, 8'h00, "row neighbour");
        // Last row boundary
        prog_row(6'h3F, 8'hC3, 8'h3C);
        wait_idle();
        rd_chk(8'h7E, 8'hC3, "last row lo");
        rd_chk(8'h7F, 8'h3C, "last row hi");
        // Window writes do not reach the array
        wr(4'h5, 8'h0A, 8'hEE);
        rd_chk(8'h0A, 8'h12, "window write");
        // Back-to-back window read then status read shows read busy
        @(posedge clk);
        rif_page <= 4'h5;
        rif_offset <= 8'h0B;
        rif_rd <= 1'b1;
        @(posedge clk);
        rif_offset <= 8'h85;
        #1;
        `CHK("b2b window", 8'h34, rif_rdata_r)
        @(posedge clk);
        rif_rd <= 1'b0;
        #1;
        `CHK("read busy", 8'h01, rif_rdata_r)
        // Zero command, reserved bit kept clear, starts nothing
        wr(4'h5, 8'h83, 8'h00);
        rd_chk(8'h83, 8'h00, "cmd zero write");
        rd_chk(8'h85, 8'h00, "no op");
        // Erase the programmed row, both bytes cleared
        wr(4'h5, 8'h82, 8'h05);
        wr(4'h5, 8'h83, 8'h02);
        rd_chk(8'h85, 8'h02, "erase busy");
        rd_chk(8'h83, 8'h02, "erase cmd read");
        wait_idle();
        arr[10] = 8'h00;
        arr[11] = 8'h00;
        rd_chk(8'h0A, 8'h00, "erase lo");
        rd_chk(8'h0B, 8'h00, "erase hi");
        rd_chk(8'h83, 8'h00, "erase done");
        // Checksum with a wrong stored byte, then with the right one
        run_csum();
        c = crc_ref();
        prog_row(6'h3F, 8'hC3, c);
        wait_idle();
        run_csum();
        wr(4'h5, 8'h84, 8'h00);
        rd_chk(8'h86, 8'h02, "csum zero write");
        give_verdict();
    end
endmodule
